/* File: common/psor_pkg.sv */
`default_nettype none

package psor_pkg;

  // Register geometry
  localparam int unsigned REG_W      = 16;
  localparam int unsigned NUM_EVENTS = 8;
  localparam int unsigned IDX_W      = 6;
  localparam int unsigned ADDR_W     = 8;

  // Register indexes; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DIGITAL_CTRL     = 6'h10;
  localparam logic [IDX_W-1:0] IDX_STRAP_OVERRIDE   = 6'h16;
  localparam logic [IDX_W-1:0] IDX_STRAP_STATUS     = 6'h17;
  localparam logic [IDX_W-1:0] IDX_EXPANDED_CONTROL = 6'h18;
  localparam logic [IDX_W-1:0] IDX_INT_CTRL_STATUS  = 6'h1b;

  localparam logic [ADDR_W-1:0] ADDR_DIGITAL_CTRL     = {IDX_DIGITAL_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STRAP_OVERRIDE   = {IDX_STRAP_OVERRIDE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STRAP_STATUS     = {IDX_STRAP_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_EXPANDED_CONTROL = {IDX_EXPANDED_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INT_CTRL_STATUS  = {IDX_INT_CTRL_STATUS, 2'b00};

  // Field positions
  localparam int unsigned OVR_B2B_BIT      = 6;
  localparam int unsigned OVR_NAND_BIT     = 5;
  localparam int unsigned OVR_RMII_BIT     = 1;
  localparam int unsigned STAT_ADDR_LSB    = 13;
  localparam int unsigned STAT_RMII_BIT    = 1;
  localparam int unsigned EXP_ENERGY_DETECT_POWERDOWN_DIS_BIT = 11;
  localparam int unsigned DIG_PLL_OFF_BIT  = 4;
  localparam int unsigned INT_EN_LSB       = 8;

  // Event flag positions in the low byte of the interrupt register
  localparam int unsigned EV_LINK_UP      = 0;
  localparam int unsigned EV_REMOTE_FAULT = 1;
  localparam int unsigned EV_LINK_DOWN    = 2;
  localparam int unsigned EV_LP_ACK       = 3;
  localparam int unsigned EV_PD_FAULT     = 4;
  localparam int unsigned EV_PAGE_RX      = 5;
  localparam int unsigned EV_RX_ERROR     = 6;
  localparam int unsigned EV_JABBER       = 7;

  // Reset values and write masks
  localparam logic [REG_W-1:0]      OVR_RESET    = 16'h0002;
  localparam logic [REG_W-1:0]      OVR_WMASK    = 16'hfbff;
  localparam logic [REG_W-1:0]      EXP_RESET    = 16'h0800;
  localparam logic [REG_W-1:0]      DIG_RESET    = 16'h0000;
  localparam logic [NUM_EVENTS-1:0] INT_EN_RESET = 8'h00;
  localparam logic [2:0]            MGMT_ADDR_0  = 3'h0;
  localparam logic [2:0]            MGMT_ADDR_3  = 3'h3;

  // Cycles after reset release before the synchronised straps are latched
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h6;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } psor_bus_state_t;

endpackage

`default_nettype wire

/* File: dv/phy_strap_override_irq_enable_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module phy_strap_override_irq_enable_regs_tb;
  import psor_pkg::*;

  logic        hclk                   = 1'b0;
  logic        hresetn                = 1'b0;
  logic        strap_rmii_pin         = 1'b0;
  logic        strap_back_to_back_pin = 1'b0;
  logic        strap_nand_tree_pin    = 1'b0;
  logic [2:0]  mgmt_address_strap     = 3'h0;
  logic [7:0]  phy_event              = 8'h0;
  logic        energy_absent          = 1'b0;
  logic        hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize, mgmt_address;
  logic [31:0] haddr, hwdata, hrdata;
  logic        rmii_mode, back_to_back_mode, nand_tree_mode;
  logic        energy_detect_powerdown_on, pll_stop, irq;
  int          error_cnt = 0;
  int          compares  = 0;
  logic [15:0] d, en;
  logic [15:0] ovr_tab [4] = '{16'h0040, 16'h0042, 16'h0020, 16'h001c};

  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;

  psor_regs uut (
    .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .strap_rmii_pin, .strap_back_to_back_pin,
    .strap_nand_tree_pin, .mgmt_address_strap, .phy_event, .energy_absent, .rmii_mode,
    .back_to_back_mode, .nand_tree_mode, .energy_detect_powerdown_on, .pll_stop,
    .mgmt_address, .irq
  );

  psor_mac_model mac (
    .hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] v;
    mac.xfer(1'b0, a, 16'h0, v);
    chk("hrdata", {16'h0, exp}, v);
    chk_bit("hresp", 1'b0, hresp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    logic [31:0] unused;
    mac.xfer(1'b1, a, v, unused);
  endtask

  task automatic do_reset(input logic [2:0] adr, input logic rm, input logic sm);
    @(posedge hclk);
    hresetn                <= 1'b0;
    mgmt_address_strap     <= adr;
    strap_rmii_pin         <= rm;
    strap_back_to_back_pin <= sm;
    strap_nand_tree_pin    <= sm;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    // Straps need several cycles to settle before they are latched
    repeat (12) @(posedge hclk);
  endtask

  task automatic settle;
    @(posedge hclk);
    #1;
  endtask

  task automatic test_done;
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    test_done();
  end

  initial begin
    void'($urandom(32'h4a1a));
    for (int p = 0; p < 2; p++) begin
      do_reset((p == 1) ? 3'h5 : 3'h0, (p == 0), (p == 0));
      d = (p == 1) ? 16'h6000 : 16'h0002;
      rd_chk(ADDR_STRAP_STATUS, d);
      chk("mgmt_address", (p == 1) ? 32'h3 : 32'h0, {29'h0, mgmt_address});
      // Strapped modes come through with the override bits at reset
      chk_bit("back_to_back_mode", (p == 0), back_to_back_mode);
      chk_bit("nand_tree_mode", (p == 0), nand_tree_mode);
      wr(ADDR_STRAP_STATUS, 16'($urandom));
      rd_chk(ADDR_STRAP_STATUS, d);
    end
    rd_chk(ADDR_STRAP_OVERRIDE, 16'h0002);
    rd_chk(ADDR_EXPANDED_CONTROL, 16'h0800);
    rd_chk(ADDR_INT_CTRL_STATUS, 16'h0000);
    rd_chk(ADDR_DIGITAL_CTRL, 16'h0000);
    rd_chk(8'h44, 16'h0000);
    chk_bit("rmii_mode", 1'b1, rmii_mode);
    chk_bit("energy_detect_powerdown_on", 1'b0, energy_detect_powerdown_on);
    // Fixed corner values first, then random ones; bit 10 always reads zero
    for (int i = 0; i < 12; i++) begin
      d = (i < 4) ? ovr_tab[i] : 16'($urandom);
      wr(ADDR_STRAP_OVERRIDE, d);
      settle();
      chk_bit("rmii_mode", d[1], rmii_mode);
      chk_bit("back_to_back_mode", d[6] & d[1], back_to_back_mode);
      chk_bit("nand_tree_mode", d[5], nand_tree_mode);
      rd_chk(ADDR_STRAP_OVERRIDE, d & 16'hfbff);
    end
    for (int i = 0; i < 8; i++) begin
      d  = (16'($urandom) & 16'hf7ff) | (i[0] ? 16'h0800 : 16'h0000);
      en = (16'($urandom) & 16'hffef) | (i[1] ? 16'h0010 : 16'h0000);
      wr(ADDR_DIGITAL_CTRL, en);
      wr(ADDR_EXPANDED_CONTROL, d);
      energy_absent <= i[2];
      repeat (2) @(posedge hclk);
      #1;
      chk_bit("energy_detect_powerdown_on", ~d[11], energy_detect_powerdown_on);
      chk_bit("pll_stop", en[4] & ~d[11] & i[2], pll_stop);
      rd_chk(ADDR_EXPANDED_CONTROL, d);
      rd_chk(ADDR_DIGITAL_CTRL, en);
    end
    en = {8'($urandom) | 8'h81, 8'h00};
    wr(ADDR_INT_CTRL_STATUS, en);
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk);
      phy_event <= 8'h1 << i;
      @(posedge hclk);
      phy_event <= 8'h0;
      settle();
      chk_bit("irq", en[8+i], irq);
      // Even events are cleared by reading, odd ones by writing one
      if (i[0]) begin
        wr(ADDR_INT_CTRL_STATUS, en | (16'h1 << i));
      end else begin
        rd_chk(ADDR_INT_CTRL_STATUS, en | (16'h1 << i));
      end
      rd_chk(ADDR_INT_CTRL_STATUS, en);
      settle();
      chk_bit("irq", 1'b0, irq);
    end
    test_done();
  end
endmodule // phy_strap_override_irq_enable_regs_tb

`default_nettype wire

/* File: dv/psor_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none

module psor_mac_model (
  // Clock
  input  wire logic        hclk,
  // AHB-Lite master side
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  import psor_pkg::*;

  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // Single word transfer; waits on hready for as long as the slave needs
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // Stale write data must not look valid once the data phase is over
    hwdata <= ~{16'h0, wd};
  endtask
endmodule // psor_mac_model

`default_nettype wire

/* File: rtl/psor_irq.sv */
`timescale 1ns/1ps
`default_nettype none

module psor_irq #(
  parameter int unsigned N = 8
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  // Event sources and enables
  input  wire logic [N-1:0] event_pulse,
  input  wire logic [N-1:0] enable,
  // Clears from the register bus
  input  wire logic         rd_clr,
  input  wire logic [N-1:0] wr_clr,
  // Flags and interrupt line
  output logic      [N-1:0] flags,
  output logic              irq
);

  logic [N-1:0] clr_mask;
  logic         any_pending;

  assign clr_mask    = rd_clr ? {N{1'b1}} : wr_clr;
  assign any_pending = |(flags & enable);

  // A new event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= '0;
    end else if (ce) begin
      flags <= (flags & ~clr_mask) | event_pulse;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= any_pending;
    end
  end

  set_wins_a : assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (event_pulse != '0) |=> (flags & $past(event_pulse)) == $past(event_pulse))
    else $error("event lost against a clear");

  irq_level_a : assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> irq == $past(any_pending))
    else $error("interrupt line does not follow enabled flags");

endmodule // psor_irq

`default_nettype wire

/* File: rtl/psor_regs.sv */
// Functional notes
// - Override bit 6 forces back-to-back mode, only together with bit 1.
// - Override bit 5 forces NAND tree test mode over the latched strap.
// - Override bit 1 forces reduced interface mode; read-write, resets to one.
// - Status bits 15:13 report latched management address, 000 or 011 only.
// - Status bit 1 reads strapped reduced interface mode; rest reserved read-only.
// - Expanded control bit 11 disables energy-detect power-down; resets to one.
// - With PLL-off bit set, PLL stops while in energy-detect power-down.
// - Interrupt bit 15 enables jabber, bit 14 receive error; reset zero.
// - Bit 13 enables page received, bit 12 parallel detect fault.
// - Bits 11, 10, 9 enable partner acknowledge, link-down, remote fault.
// - Low byte holds event flags, each set whatever its enable, cleared on read.
// - Reserved read-write fields reset to zero and steer nothing.
`timescale 1ns/1ps
`default_nettype none

module psor_regs (
  // Clock, reset, enable
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  input  wire logic                           ce,
  // AHB-Lite slave
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic      [31:0]                    hrdata,
  output logic                                hreadyout,
  output logic                                hresp,
  // Strap pins
  input  wire logic                           strap_rmii_pin,
  input  wire logic                           strap_back_to_back_pin,
  input  wire logic                           strap_nand_tree_pin,
  input  wire logic [2:0]                     mgmt_address_strap,
  // Transceiver events and state
  input  wire logic [psor_pkg::NUM_EVENTS-1:0] phy_event,
  input  wire logic                           energy_absent,
  // Operating mode outputs
  output logic                                rmii_mode,
  output logic                                back_to_back_mode,
  output logic                                nand_tree_mode,
  output logic                                energy_detect_powerdown_on,
  output logic                                pll_stop,
  output logic      [2:0]                     mgmt_address,
  // Interrupt
  output logic                                irq
);

  import psor_pkg::*;

  function automatic logic is_reg(input logic [31:0] a, input logic [ADDR_W-1:0] ra);
    is_reg = (a[31:ADDR_W] == '0) && (a[ADDR_W-1:0] == ra);
  endfunction

  psor_bus_state_t           bus_state;
  psor_bus_state_t           next_bus_state;
  logic [31:0]               addr_q;
  logic                      accept;
  logic                      wr_phase;
  logic                      rd_phase;

  logic [REG_W-1:0]          strap_override;
  logic [REG_W-1:0]          expanded_control;
  logic [REG_W-1:0]          digital_ctrl;
  logic [NUM_EVENTS-1:0]     int_enable;
  logic [NUM_EVENTS-1:0]     int_flags;
  logic [REG_W-1:0]          strap_status;
  logic [REG_W-1:0]          read_value;

  logic [NUM_EVENTS-1:0]     wr_flag_clr;
  logic                      rd_flag_clr;
  logic                      energy_detect_powerdown_disabled;
  logic [NUM_EVENTS-1:0]     wdata_enable;

  logic [2:0]                strap_sync;
  logic [2:0]                addr_sync;
  logic                      strap_rmii_q;
  logic                      strap_b2b_q;
  logic                      strap_nand_q;
  logic [2:0]                strap_addr_q;
  logic                      straps_latched;
  logic [2:0]                settle_cnt;

  // Bus front end
  assign accept   = hsel && htrans[1] && hready && ce;
  assign wr_phase = ce && (bus_state == BUS_WRITE);
  assign rd_phase = ce && (bus_state == BUS_READ);

  always_comb begin
    next_bus_state = BUS_IDLE;
    unique case (bus_state)
      BUS_IDLE, BUS_WRITE: begin
        if (accept) begin
          next_bus_state = hwrite ? BUS_WRITE : BUS_READ;
        end
      end
      BUS_READ: begin
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= BUS_IDLE;
    end else if (ce) begin
      bus_state <= next_bus_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 32'h0000_0000;
    end else if (accept) begin
      addr_q <= haddr;
    end
  end

  // Reads take one wait state so a write just before them is always seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else if (ce) begin
      if (accept && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (bus_state == BUS_READ) begin
        hreadyout <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else if (ce) begin
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_phase) begin
      hrdata <= {16'h0000, read_value};
    end
  end

  // Register reads; unmapped offsets read zero
  always_comb begin
    read_value = '0;
    if (is_reg(addr_q, ADDR_DIGITAL_CTRL)) begin
      read_value = digital_ctrl;
    end else if (is_reg(addr_q, ADDR_STRAP_OVERRIDE)) begin
      read_value = strap_override;
    end else if (is_reg(addr_q, ADDR_STRAP_STATUS)) begin
      read_value = strap_status;
    end else if (is_reg(addr_q, ADDR_EXPANDED_CONTROL)) begin
      read_value = expanded_control;
    end else if (is_reg(addr_q, ADDR_INT_CTRL_STATUS)) begin
      read_value = {int_enable, int_flags};
    end
  end

  // Writable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_override <= OVR_RESET;
    end else if (wr_phase && is_reg(addr_q, ADDR_STRAP_OVERRIDE)) begin
      strap_override <= hwdata[REG_W-1:0] & OVR_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      expanded_control <= EXP_RESET;
    end else if (wr_phase && is_reg(addr_q, ADDR_EXPANDED_CONTROL)) begin
      expanded_control <= hwdata[REG_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      digital_ctrl <= DIG_RESET;
    end else if (wr_phase && is_reg(addr_q, ADDR_DIGITAL_CTRL)) begin
      digital_ctrl <= hwdata[REG_W-1:0];
    end
  end

  assign wdata_enable = hwdata[INT_EN_LSB +: NUM_EVENTS];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_enable <= INT_EN_RESET;
    end else if (wr_phase && is_reg(addr_q, ADDR_INT_CTRL_STATUS)) begin
      int_enable <= wdata_enable;
    end
  end

  // Flags clear on a read of the register, or by writing ones
  assign rd_flag_clr = rd_phase && is_reg(addr_q, ADDR_INT_CTRL_STATUS);
  assign wr_flag_clr = (wr_phase && is_reg(addr_q, ADDR_INT_CTRL_STATUS))
                       ? hwdata[NUM_EVENTS-1:0] : '0;

  psor_irq #(
    .N (NUM_EVENTS)
  ) u_irq (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ce          (ce),
    .event_pulse (phy_event),
    .enable      (int_enable),
    .rd_clr      (rd_flag_clr),
    .wr_clr      (wr_flag_clr),
    .flags       (int_flags),
    .irq         (irq)
  );

  // Strap capture
  psor_sync #(
    .W (3)
  ) u_strap_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .async_in ({strap_nand_tree_pin, strap_back_to_back_pin, strap_rmii_pin}),
    .sync_out (strap_sync)
  );

  psor_sync #(
    .W (3)
  ) u_addr_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .async_in (mgmt_address_strap),
    .sync_out (addr_sync)
  );

  // Straps are only taken once the synchronisers have filled after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt     <= 3'h0;
      straps_latched <= 1'b0;
    end else if (ce && !straps_latched) begin
      settle_cnt     <= settle_cnt + 3'h1;
      straps_latched <= (settle_cnt == STRAP_SETTLE_CYCLES);
    end
  end

  // Only addresses 0 and 3 exist; any nonzero strap selects 3
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_rmii_q <= 1'b0;
      strap_b2b_q  <= 1'b0;
      strap_nand_q <= 1'b0;
      strap_addr_q <= MGMT_ADDR_0;
    end else if (ce && !straps_latched && (settle_cnt == STRAP_SETTLE_CYCLES)) begin
      strap_rmii_q <= strap_sync[0];
      strap_b2b_q  <= strap_sync[1];
      strap_nand_q <= strap_sync[2];
      strap_addr_q <= (addr_sync == 3'h0) ? MGMT_ADDR_0 : MGMT_ADDR_3;
    end
  end

  always_comb begin
    strap_status = '0;
    strap_status[STAT_ADDR_LSB +: 3] = strap_addr_q;
    strap_status[STAT_RMII_BIT]      = strap_rmii_q;
  end

  // Operating modes, registered one cycle after the controlling write
  assign energy_detect_powerdown_disabled = expanded_control[EXP_ENERGY_DETECT_POWERDOWN_DIS_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rmii_mode         <= 1'b0;
      back_to_back_mode <= 1'b0;
      nand_tree_mode    <= 1'b0;
    end else if (ce) begin
      rmii_mode         <= strap_override[OVR_RMII_BIT] | strap_rmii_q;
      back_to_back_mode <= (strap_override[OVR_B2B_BIT] & strap_override[OVR_RMII_BIT])
                           | strap_b2b_q;
      nand_tree_mode    <= strap_override[OVR_NAND_BIT] | strap_nand_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      energy_detect_powerdown_on <= 1'b0;
      pll_stop                   <= 1'b0;
    end else if (ce) begin
      energy_detect_powerdown_on <= !energy_detect_powerdown_disabled;
      pll_stop <= digital_ctrl[DIG_PLL_OFF_BIT] && !energy_detect_powerdown_disabled && energy_absent;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mgmt_address <= MGMT_ADDR_0;
    end else if (ce) begin
      mgmt_address <= strap_addr_q;
    end
  end

  // Checks
  b2b_force_a : assert property (@(posedge hclk) disable iff (!hresetn)
    ce && strap_override[OVR_B2B_BIT] && strap_override[OVR_RMII_BIT] |=> back_to_back_mode)
    else $error("back-to-back override not applied");

  b2b_needs_rmii_a : assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !strap_override[OVR_RMII_BIT] && !strap_b2b_q |=> !back_to_back_mode)
    else $error("back-to-back forced without reduced interface bit");

  nand_force_a : assert property (@(posedge hclk) disable iff (!hresetn)
    ce && strap_override[OVR_NAND_BIT] |=> nand_tree_mode)
    else $error("nand tree override not applied");

  rmii_force_a : assert property (@(posedge hclk) disable iff (!hresetn)
    ce && strap_override[OVR_RMII_BIT] |=> rmii_mode)
    else $error("reduced interface override not applied");

  addr_status_a : assert property (@(posedge hclk) disable iff (!hresetn)
    strap_status[STAT_ADDR_LSB +: 3] == MGMT_ADDR_0 ||
    strap_status[STAT_ADDR_LSB +: 3] == MGMT_ADDR_3)
    else $error("unsupported management address reported");

  rmii_status_a : assert property (@(posedge hclk) disable iff (!hresetn)
    strap_status[STAT_RMII_BIT] == strap_rmii_q && (strap_status & 16'h1ffd) == 16'h0000)
    else $error("strap status reserved or reduced interface bit wrong");

  energy_detect_powerdown_ctrl_a : assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> energy_detect_powerdown_on == !$past(energy_detect_powerdown_disabled))
    else $error("power-down enable does not follow control bit");

  pll_keep_a : assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (!digital_ctrl[DIG_PLL_OFF_BIT] || energy_detect_powerdown_disabled) |=> !pll_stop)
    else $error("pll stopped while it must run");

  enable_write_a : assert property (@(posedge hclk) disable iff (!hresetn)
    wr_phase && is_reg(addr_q, ADDR_INT_CTRL_STATUS) |=> int_enable == $past(wdata_enable))
    else $error("interrupt enables not written");

  read_clear_a : assert property (@(posedge hclk) disable iff (!hresetn)
    rd_flag_clr |=> (int_flags & ~$past(phy_event)) == '0)
    else $error("flags not cleared by read");

  reset_value_a : assert property (@(posedge hclk)
    $rose(hresetn) |-> strap_override == OVR_RESET && expanded_control == EXP_RESET)
    else $error("reset values wrong");

  override_now_a : assert property (@(posedge hclk) disable iff (!hresetn)
    wr_phase && is_reg(addr_q, ADDR_STRAP_OVERRIDE) && hwdata[OVR_NAND_BIT] ##1 ce
    |=> nand_tree_mode)
    else $error("override write did not reach mode");

endmodule // psor_regs

`default_nettype wire

/* File: rtl/psor_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module psor_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  // Asynchronous input and filtered result
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // First stage feeds only the second; the filter looks at stages two and three
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (ce) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_out <= '0;
    end else if (ce && (stage2 == stage3)) begin
      sync_out <= stage3;
    end
  end

endmodule // psor_sync

`default_nettype wire
